//--- src/dram_wb_pkg.sv
package dram_wb_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int DEV_W = 5;   // Device address
  localparam int BANK_W = 4;  // Bank address
  localparam int COL_W = 6;   // Column address
  localparam int ROW_W = 9;   // Row address
  localparam int DATA_W = 128; // One dualoct
  localparam int MASK_W = 16; // One bit per data byte
  localparam int NUM_BANKS = 16;

  // ----------------------------------------------------------------
  // Timing counts in packet times (one packet time = one clock)
  // ----------------------------------------------------------------
  localparam int RETIRE_DELAY = 2;      // Store to retire slot
  localparam int WRITE_DATA_DELAY = 1;  // Store to data dualoct
  localparam int AUTOCLOSE_OFFSET = 1;  // Retire to implied close
  localparam int ROW_ACTIVE_MIN = 5;    // Open to close
  localparam int RETIRE_TO_CLOSE = 1;   // Retire to close
  localparam int CLOSE_TO_OPEN = 2;     // Close to open
  localparam int ROW_TO_COLUMN = 3;     // Open to first retire
  localparam int CNT_W = 4;             // Interval counter width
  localparam int FIFO_DEPTH = 4;        // Request FIFO depth

  // ----------------------------------------------------------------
  // Column command encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    COL_NONE = 3'h0,
    COL_STORE = 3'h1,
    COL_STORE_AUTOCLOSE = 3'h2,
    COL_FETCH = 3'h3,
    COL_NOOP = 3'h4
  } col_op_t;

  // Row command encodings
  typedef enum logic [1:0] {
    ROW_NONE = 2'h0,
    ROW_OPEN = 2'h1,
    ROW_CLOSE = 2'h2
  } row_op_t;

  // Host request kinds
  typedef enum logic [1:0] {
    REQ_STORE = 2'h0,
    REQ_FETCH = 2'h1,
    REQ_STORE_CLOSE = 2'h2
  } req_kind_t;

  // Host request word
  typedef struct packed {
    req_kind_t kind;
    logic [DEV_W-1:0] dev;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [MASK_W-1:0] mask;
    logic mask_en;
    logic [DATA_W-1:0] data;
  } req_t;

  localparam int REQ_W = $bits(req_t);

endpackage

//--- src/dram_link_if.sv
`timescale 1ns/1ps
// Row, column, mask and data buses between controller and device
interface dram_link_if;
  // Row bus: one row packet per clock
  logic row_valid;
  dram_wb_pkg::row_op_t row_op;
  logic [dram_wb_pkg::DEV_W-1:0] row_dev;
  logic [dram_wb_pkg::BANK_W-1:0] row_bank;
  logic [dram_wb_pkg::ROW_W-1:0] row_addr;
  // Column bus: framed column command packet
  logic col_frame;
  dram_wb_pkg::col_op_t col_op;
  logic [dram_wb_pkg::DEV_W-1:0] col_dev;
  logic [dram_wb_pkg::BANK_W-1:0] col_bank;
  logic [dram_wb_pkg::COL_W-1:0] col_addr;
  // Column mask packet
  logic mask_valid;
  logic [dram_wb_pkg::MASK_W-1:0] byte_mask;
  // Write data dualoct and read data return
  logic wdata_valid;
  logic [dram_wb_pkg::DATA_W-1:0] wdata;
  logic rdata_valid;
  logic [dram_wb_pkg::DATA_W-1:0] rdata;

  modport controller (
    output row_valid, row_op, row_dev, row_bank, row_addr,
    output col_frame, col_op, col_dev, col_bank, col_addr,
    output mask_valid, byte_mask, wdata_valid, wdata,
    input rdata_valid, rdata
  );
  modport device (
    input row_valid, row_op, row_dev, row_bank, row_addr,
    input col_frame, col_op, col_dev, col_bank, col_addr,
    input mask_valid, byte_mask, wdata_valid, wdata,
    output rdata_valid, rdata
  );
endinterface

//--- src/req_fifo.sv
`timescale 1ns/1ps
// Small flip-flop FIFO with valid/ready on both sides
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse depths the pointer logic cannot wrap
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("req_fifo DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_state_t;

  fifo_state_t state_reg; // Registered state
  fifo_state_t state_next; // Next state
  logic full;
  logic empty;

  assign empty = state_reg.wr_ptr == state_reg.rd_ptr;
  assign full = (state_reg.wr_ptr[AW] != state_reg.rd_ptr[AW]) &&
                (state_reg.wr_ptr[AW-1:0] == state_reg.rd_ptr[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = state_reg.mem[state_reg.rd_ptr[AW-1:0]];

  // Push and pop
  always_comb begin
    state_next = state_reg;
    if (in_valid_in && !full) begin
      state_next.mem[state_reg.wr_ptr[AW-1:0]] = in_data_in;
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (out_ready_in && !empty) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

//--- src/dram_wb_controller.sv
`timescale 1ns/1ps
// What this block does
// - Time packets from each packet's end
// - Row-to-column delay met at first retire
// - Store carries bank/column; open carries row
// - Data dualoct one write-data delay later
// - Same-bank column packets one interval apart
// - Mask packet aligns with retiring column packet
// - No mask means all bytes written
// - Delayed retire delays its mask too; here the mask always goes RETIRE_DELAY after the store
// - Close no earlier than row-active minimum
// - Close after retire-to-close interval
// - Reopen after row cycle and close-to-open
// - Same bank transactions do not overlap
// - Store loads buffer, not sense amp
// - Retire one retire delay after store
// - Skipped retire waits for non-own-fetch packet
// - Fetch before retire old, after new
// - Own fetch in slot postpones retire
// - Other fetch, store or no-op retires
// - Store, store, fetch needs no-op gap
// - Retire writes row open at retire
// - Never close with unretired buffer
// - Store retires other devices' old buffers
// - Autoclose store closes after offset
module dram_wb_controller (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // User request side
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire dram_wb_pkg::req_t req_in,
  // Read answer
  output logic resp_valid_out,
  output logic [dram_wb_pkg::DATA_W-1:0] resp_data_out,
  // Link
  dram_link_if.controller link
);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OPEN = 3'b001,
    S_COL = 3'b011,
    S_NOOP = 3'b010,
    S_FLUSH = 3'b110,
    S_CLOSE = 3'b111,
    S_PRE = 3'b101
  } seq_t;

  typedef struct packed {
    seq_t st;
    logic [dram_wb_pkg::CNT_W-1:0] cnt;     // Interval counter
    logic [dram_wb_pkg::CNT_W-1:0] act_cnt; // Since row open
    dram_wb_pkg::req_t cur;                 // Request in flight
    logic [dram_wb_pkg::DATA_W-1:0] wd;     // Data queued for bus
    logic [dram_wb_pkg::WRITE_DATA_DELAY:0] wd_pipe;
    logic [dram_wb_pkg::RETIRE_DELAY:0] mask_pipe;
    logic [dram_wb_pkg::MASK_W-1:0] msk0;
    logic [dram_wb_pkg::MASK_W-1:0] msk1;
    logic resp_v;
    logic [dram_wb_pkg::DATA_W-1:0] resp_d;
  } ctl_state_t;

  ctl_state_t state_reg; // Registered state
  ctl_state_t state_next; // Next state
  logic fifo_valid;
  logic fifo_pop;
  dram_wb_pkg::req_t fifo_req;
  logic [dram_wb_pkg::REQ_W-1:0] fifo_raw;

  // ----------------------------------------------------------------
  // Request buffering
  // ----------------------------------------------------------------
  // Back-pressure reaches the user through req_ready_out
  req_fifo #(
    .WIDTH(dram_wb_pkg::REQ_W),
    .DEPTH(dram_wb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(req_valid_in),
    .in_ready_out(req_ready_out),
    .in_data_in(req_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_raw)
  );
  assign fifo_req = dram_wb_pkg::req_t'(fifo_raw);
  assign fifo_pop = (state_reg.st == S_IDLE) && fifo_valid;

  // Link outputs from registered sequencer pipes; answer outputs from registered read data
  assign resp_valid_out = state_reg.resp_v;
  assign resp_data_out = state_reg.resp_d;
  assign link.wdata_valid = state_reg.wd_pipe[dram_wb_pkg::WRITE_DATA_DELAY-1];
  assign link.wdata = state_reg.wd;
  assign link.mask_valid = state_reg.mask_pipe[dram_wb_pkg::RETIRE_DELAY-1];
  assign link.byte_mask = state_reg.msk1;

  // ----------------------------------------------------------------
  // Sequencer: open, column, flush slots, close, precharge wait
  // ----------------------------------------------------------------
  // One request is a whole transaction, so same-bank work never
  // overlaps; the close waits for the retire to finish.
  always_comb begin
    state_next = state_reg;
    state_next.resp_v = link.rdata_valid;
    if (link.rdata_valid) begin
      state_next.resp_d = link.rdata;
    end
    state_next.wd_pipe = {state_reg.wd_pipe[dram_wb_pkg::WRITE_DATA_DELAY-1:0],
                          1'b0};
    state_next.mask_pipe = {state_reg.mask_pipe[dram_wb_pkg::RETIRE_DELAY-1:0],
                            1'b0};
    state_next.msk1 = state_reg.msk0;
    if (state_reg.act_cnt != '1) begin
      state_next.act_cnt = state_reg.act_cnt + 1'b1;
    end
    if (state_reg.cnt != '0) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
    link.row_valid = 1'b0;
    link.row_op = dram_wb_pkg::ROW_NONE;
    link.row_dev = state_reg.cur.dev;
    link.row_bank = state_reg.cur.bank;
    link.row_addr = state_reg.cur.row;
    link.col_frame = 1'b0;
    link.col_op = dram_wb_pkg::COL_NONE;
    link.col_dev = state_reg.cur.dev;
    link.col_bank = state_reg.cur.bank;
    link.col_addr = state_reg.cur.col;
    case (state_reg.st)
      S_IDLE: begin
        if (fifo_valid) begin
          state_next.cur = fifo_req;
          state_next.st = S_OPEN;
        end
      end
      S_OPEN: begin
        // Open carries device, bank and row
        link.row_valid = 1'b1;
        link.row_op = dram_wb_pkg::ROW_OPEN;
        state_next.act_cnt = '0;
        // Column packet placed so first retire meets open delay
        state_next.cnt = dram_wb_pkg::CNT_W'(dram_wb_pkg::ROW_TO_COLUMN -
                                             dram_wb_pkg::RETIRE_DELAY);
        state_next.st = S_COL;
      end
      S_COL: begin
        if (state_reg.cnt == '0) begin
          link.col_frame = 1'b1;
          state_next.st = S_NOOP;
          if (state_reg.cur.kind == dram_wb_pkg::REQ_FETCH) begin
            link.col_op = dram_wb_pkg::COL_FETCH;
          end else begin
            // Store: data one write-data delay later
            link.col_op = (state_reg.cur.kind ==
                           dram_wb_pkg::REQ_STORE_CLOSE) ?
                          dram_wb_pkg::COL_STORE_AUTOCLOSE :
                          dram_wb_pkg::COL_STORE;
            state_next.wd = state_reg.cur.data;
            state_next.wd_pipe[0] = 1'b1;
            // Mask rides with the retiring packet
            state_next.mask_pipe[0] = state_reg.cur.mask_en;
            state_next.msk0 = state_reg.cur.mask;
          end
          state_next.cnt = dram_wb_pkg::CNT_W'(dram_wb_pkg::RETIRE_DELAY - 1);
        end
      end
      S_NOOP: begin
        // Column no-ops fill slots so the retire happens on time and
        // a later fetch cannot overwrite the buffer
        link.col_frame = 1'b1;
        link.col_op = dram_wb_pkg::COL_NOOP;
        if (state_reg.cnt == '0) begin
          state_next.cnt = dram_wb_pkg::CNT_W'(dram_wb_pkg::RETIRE_TO_CLOSE);
          state_next.st = (state_reg.cur.kind ==
                           dram_wb_pkg::REQ_STORE_CLOSE) ? S_PRE : S_FLUSH;
          if (state_reg.cur.kind == dram_wb_pkg::REQ_STORE_CLOSE) begin
            state_next.cnt = dram_wb_pkg::CNT_W'(
              dram_wb_pkg::AUTOCLOSE_OFFSET + dram_wb_pkg::CLOSE_TO_OPEN);
          end
        end
      end
      S_FLUSH: begin
        // Buffer retired in the last no-op slot; close only after retire-to-close,
        // so no bank is closed with a pending buffer
        if (state_reg.cnt == '0) begin
          state_next.st = S_CLOSE;
        end
      end
      S_CLOSE: begin
        // Wait out the row-active minimum
        if (state_reg.act_cnt >=
            dram_wb_pkg::CNT_W'(dram_wb_pkg::ROW_ACTIVE_MIN)) begin
          link.row_valid = 1'b1;
          link.row_op = dram_wb_pkg::ROW_CLOSE;
          state_next.cnt = dram_wb_pkg::CNT_W'(dram_wb_pkg::CLOSE_TO_OPEN);
          state_next.st = S_PRE;
        end
      end
      S_PRE: begin
        // Close-to-open and row cycle before next open
        if (state_reg.cnt == '0 && state_reg.act_cnt >=
            dram_wb_pkg::CNT_W'(dram_wb_pkg::ROW_ACTIVE_MIN +
                                dram_wb_pkg::CLOSE_TO_OPEN)) begin
          state_next.st = S_IDLE;
        end
      end
      default: begin
        state_next.st = S_IDLE;
      end
    endcase
  end

  // State register; all bus timing counts from packet end
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

//--- src/dram_wb_device.sv
`timescale 1ns/1ps
// Device end: write buffer with delayed retire into sense amps
module dram_wb_device #(
  parameter logic [dram_wb_pkg::DEV_W-1:0] DEVICE_ID = 5'h00
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Link
  dram_link_if.device link,
  // Status
  output logic buf_pending_out,
  output logic autoclose_out
);
  typedef struct packed {
    // Write buffer: bank and column only, no row
    logic wb_full;
    logic wb_wait_data;
    logic [dram_wb_pkg::BANK_W-1:0] wb_bank;
    logic [dram_wb_pkg::COL_W-1:0] wb_col;
    logic [dram_wb_pkg::DATA_W-1:0] wb_data;
    logic wb_autoclose;
    logic [dram_wb_pkg::CNT_W-1:0] age;  // Packets since store
    logic [dram_wb_pkg::CNT_W-1:0] ac_cnt;
    logic ac_pend;
    logic [dram_wb_pkg::NUM_BANKS-1:0] open;
    logic [dram_wb_pkg::NUM_BANKS-1:0][dram_wb_pkg::ROW_W-1:0] row;
    // Sense amp word for each bank at its current column
    logic [dram_wb_pkg::NUM_BANKS-1:0][dram_wb_pkg::DATA_W-1:0] amp;
    logic rv;
    logic [dram_wb_pkg::DATA_W-1:0] rd;
  } dev_state_t;

  dev_state_t state_reg; // Registered state
  dev_state_t state_next; // Next state
  logic mine;
  logic own_fetch;
  logic retire;
  logic [dram_wb_pkg::DATA_W-1:0] merged;

  // Byte merge: bytes whose mask bit is set are written, no mask writes all
  function automatic logic [dram_wb_pkg::DATA_W-1:0] merge_bytes(
    input logic [dram_wb_pkg::DATA_W-1:0] old_d,
    input logic [dram_wb_pkg::DATA_W-1:0] new_d,
    input logic [dram_wb_pkg::MASK_W-1:0] msk,
    input logic use_msk
  );
    logic [dram_wb_pkg::DATA_W-1:0] res;
    res = old_d;
    for (int i = 0; i < dram_wb_pkg::MASK_W; i++) begin
      if (!use_msk || msk[i]) begin
        res[i*8 +: 8] = new_d[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign mine = link.col_dev == DEVICE_ID;
  assign own_fetch = link.col_op == dram_wb_pkg::COL_FETCH && mine;
  // Retire on first framed packet at or after the slot that is not
  // our own fetch; any store also retires old buffers
  assign retire = state_reg.wb_full && !state_reg.wb_wait_data &&
                  link.col_frame && !own_fetch &&
                  state_reg.age >= dram_wb_pkg::CNT_W'(
                    dram_wb_pkg::RETIRE_DELAY);
  assign merged = merge_bytes(state_reg.amp[state_reg.wb_bank],
                              state_reg.wb_data, link.byte_mask,
                              link.mask_valid);
  assign buf_pending_out = state_reg.wb_full;
  assign autoclose_out = state_reg.ac_pend && state_reg.ac_cnt == '0;
  assign link.rdata_valid = state_reg.rv;
  assign link.rdata = state_reg.rd;

  // ----------------------------------------------------------------
  // Column, row and retire handling
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rv = 1'b0;
    if (link.col_frame && state_reg.age != '1) begin
      state_next.age = state_reg.age + 1'b1;
    end
    if (state_reg.wb_wait_data && link.wdata_valid) begin
      state_next.wb_data = link.wdata;
      state_next.wb_wait_data = 1'b0;
    end
    // Fetch sees sense amp; before retire that is old data
    if (link.col_frame && own_fetch) begin
      state_next.rv = 1'b1;
      state_next.rd = state_reg.amp[link.col_bank];
    end
    // Close countdown first, so a fresh set wins
    if (state_reg.ac_pend) begin
      if (state_reg.ac_cnt == '0) begin
        state_next.ac_pend = 1'b0;
        state_next.open[state_reg.wb_bank] = 1'b0;
      end else begin
        state_next.ac_cnt = state_reg.ac_cnt - 1'b1;
      end
    end
    // Retire into whatever row is open now
    if (retire) begin
      state_next.amp[state_reg.wb_bank] = merged;
      state_next.wb_full = 1'b0;
      if (state_reg.wb_autoclose) begin
        // Implied close offset from the retiring packet
        state_next.ac_pend = 1'b1;
        state_next.ac_cnt = dram_wb_pkg::CNT_W'(
          dram_wb_pkg::AUTOCLOSE_OFFSET - 1);
      end
    end
    // New store to us loads the buffer
    if (link.col_frame && mine &&
        (link.col_op == dram_wb_pkg::COL_STORE ||
         link.col_op == dram_wb_pkg::COL_STORE_AUTOCLOSE)) begin
      state_next.wb_full = 1'b1;
      state_next.wb_wait_data = 1'b1;
      state_next.wb_bank = link.col_bank;
      state_next.wb_col = link.col_addr;
      state_next.wb_autoclose =
        link.col_op == dram_wb_pkg::COL_STORE_AUTOCLOSE;
      state_next.age = dram_wb_pkg::CNT_W'(1);
    end
    // Row packets: open carries the row, close drops it
    if (link.row_valid && link.row_dev == DEVICE_ID) begin
      if (link.row_op == dram_wb_pkg::ROW_OPEN) begin
        state_next.open[link.row_bank] = 1'b1;
        state_next.row[link.row_bank] = link.row_addr;
      end else if (link.row_op == dram_wb_pkg::ROW_CLOSE) begin
        state_next.open[link.row_bank] = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

//--- tb/dram_wb_checker.sv
`timescale 1ns/1ps
// Watches the link between controller and device
module dram_wb_checker #(
  parameter logic [dram_wb_pkg::DEV_W-1:0] DEV_ID = 5'h00
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Row bus
  input wire logic row_valid,
  input wire dram_wb_pkg::row_op_t row_op,
  // Column bus
  input wire logic col_frame,
  input wire dram_wb_pkg::col_op_t col_op,
  input wire logic [dram_wb_pkg::DEV_W-1:0] col_dev,
  // Mask, write data and read data
  input wire logic mask_valid,
  input wire logic wdata_valid,
  input wire logic rdata_valid
);
  // ----------------------------------------------------------------
  // Interval counters
  // ----------------------------------------------------------------
  localparam int RD = dram_wb_pkg::RETIRE_DELAY; // Store to retire slot
  // Cycles since the last open, close and column packet
  typedef struct packed {
    logic [7:0] open_age;
    logic [7:0] close_age;
    logic [7:0] col_age;
  } age_t;
  age_t age_reg;
  age_t age_next;
  logic is_open;
  logic is_close;
  logic is_store;
  logic is_own_fetch;
  assign is_open = row_valid && row_op == dram_wb_pkg::ROW_OPEN;
  assign is_close = row_valid && row_op == dram_wb_pkg::ROW_CLOSE;
  assign is_store = col_frame && (col_op == dram_wb_pkg::COL_STORE ||
                    col_op == dram_wb_pkg::COL_STORE_AUTOCLOSE);
  assign is_own_fetch = col_frame && col_op == dram_wb_pkg::COL_FETCH &&
                        col_dev == DEV_ID;
  // Saturate so an old event never looks recent again
  function automatic logic [7:0] bump(input logic [7:0] a);
    return (a == 8'hff) ? a : a + 8'h01;
  endfunction
  // Next ages
  always_comb begin
    age_next = age_reg;
    age_next.open_age = is_open ? 8'h01 : bump(age_reg.open_age);
    age_next.close_age = is_close ? 8'h01 : bump(age_reg.close_age);
    age_next.col_age = col_frame ? 8'h01 : bump(age_reg.col_age);
  end
  // Reset to "long ago" so the first open is never judged too early
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      age_reg <= '1;
    end else begin
      age_reg <= age_next;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  chk_data_after_store: assert property (
    is_store |-> ##1 wdata_valid) else $error("no data after store");
  chk_data_has_store: assert property (
    wdata_valid |-> $past(is_store)) else $error("stray write data");
  chk_mask_on_column: assert property (
    mask_valid |-> col_frame) else $error("mask without column packet");
  chk_mask_retire_slot: assert property (
    mask_valid |-> $past(is_store, RD)) else $error("mask off slot");
  chk_retire_slot_framed: assert property (
    is_store |-> ##RD (col_frame && col_op != dram_wb_pkg::COL_FETCH))
    else $error("retire slot not usable");
  chk_open_to_column: assert property (
    is_store |-> age_reg.open_age + RD >= dram_wb_pkg::ROW_TO_COLUMN)
    else $error("store too soon after open");
  chk_close_after_open: assert property (
    is_close |-> age_reg.open_age >= dram_wb_pkg::ROW_ACTIVE_MIN)
    else $error("close too soon after open");
  chk_close_after_retire: assert property (
    is_close |-> age_reg.col_age >= dram_wb_pkg::RETIRE_TO_CLOSE)
    else $error("close too soon after column");
  chk_reopen_gap: assert property (
    is_open |-> age_reg.close_age >= dram_wb_pkg::CLOSE_TO_OPEN)
    else $error("open too soon after close");
  chk_fetch_answer: assert property (
    is_own_fetch |-> ##1 rdata_valid) else $error("fetch not answered");
  // Main scenarios reached
  cover property (is_store);
  cover property (mask_valid);
  cover property (is_close);
  cover property (rdata_valid);
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TIMEOUT_CYCLES = 5000; // Whole run needs about 270
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic req_valid_in = 1'b0;
  logic req_ready_out;
  dram_wb_pkg::req_t req_in = '0;
  logic resp_valid_out;
  logic [dram_wb_pkg::DATA_W-1:0] resp_data_out;
  logic buf_pending_out;
  logic autoclose_out;
  logic saw_full = 1'b0; // Request FIFO refused at least once
  logic saw_pending = 1'b0; // Write buffer held an entry
  int n_autoclose = 0;
  // Expected sense amp, one word per bank
  logic [dram_wb_pkg::DATA_W-1:0] amp_model [dram_wb_pkg::NUM_BANKS];
  always #12.5 sys_clk_in = ~sys_clk_in;
  dram_link_if dram_link_if_inst ();
  dram_wb_controller dram_wb_controller_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .req_in(req_in), .resp_valid_out(resp_valid_out),
    .resp_data_out(resp_data_out), .link(dram_link_if_inst));
  dram_wb_device #(.DEVICE_ID(5'h00)) dram_wb_device_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .link(dram_link_if_inst), .buf_pending_out(buf_pending_out),
    .autoclose_out(autoclose_out));
  dram_wb_checker #(.DEV_ID(5'h00)) dram_wb_checker_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .row_valid(dram_link_if_inst.row_valid),
    .row_op(dram_link_if_inst.row_op),
    .col_frame(dram_link_if_inst.col_frame),
    .col_op(dram_link_if_inst.col_op),
    .col_dev(dram_link_if_inst.col_dev),
    .mask_valid(dram_link_if_inst.mask_valid),
    .wdata_valid(dram_link_if_inst.wdata_valid),
    .rdata_valid(dram_link_if_inst.rdata_valid));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hold the request until the edge that takes it
  task automatic send(input dram_wb_pkg::req_t r);
    int waited;
    waited = 0;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_in <= r;
    @(negedge sys_clk_in);
    while (req_ready_out !== 1'b1 && waited < 300) begin
      @(negedge sys_clk_in);
      waited++;
    end
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
  endtask
  // Store, and update the expected amp only for our own device
  task automatic store(input dram_wb_pkg::req_kind_t kind,
      input logic [dram_wb_pkg::DEV_W-1:0] dev,
      input logic [dram_wb_pkg::BANK_W-1:0] bank,
      input logic [dram_wb_pkg::DATA_W-1:0] data,
      input logic [dram_wb_pkg::MASK_W-1:0] mask, input logic men);
    dram_wb_pkg::req_t r;
    r = '0;
    r.kind = kind;
    r.dev = dev;
    r.bank = bank;
    r.row = 9'h011;
    r.col = 6'h05;
    r.mask = mask;
    r.mask_en = men;
    r.data = data;
    send(r);
    for (int i = 0; i < dram_wb_pkg::MASK_W; i++) begin
      if (dev == 5'h00 && (!men || mask[i])) begin
        amp_model[bank][8*i +: 8] = data[8*i +: 8];
      end
    end
  endtask
  // Fetch and compare with the expected amp
  task automatic fetch(input logic [dram_wb_pkg::BANK_W-1:0] bank);
    dram_wb_pkg::req_t r;
    int waited;
    r = '0;
    r.kind = dram_wb_pkg::REQ_FETCH;
    r.bank = bank;
    r.row = 9'h011;
    r.col = 6'h05;
    send(r);
    waited = 0;
    while (resp_valid_out !== 1'b1 && waited < 300) begin
      @(negedge sys_clk_in);
      waited++;
    end
    `CHECK("fetch data", amp_model[bank], resp_data_out)
    @(negedge sys_clk_in);
  endtask
  // ----------------------------------------------------------------
  // Monitors, timeout and main sequence
  // ----------------------------------------------------------------
  always @(negedge sys_clk_in) begin
    if (req_valid_in && req_ready_out === 1'b0) saw_full = 1'b1;
    if (buf_pending_out === 1'b1) saw_pending = 1'b1;
    if (autoclose_out === 1'b1) n_autoclose++;
  end
  // A hang counts as a failure
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    for (int b = 0; b < dram_wb_pkg::NUM_BANKS; b++) amp_model[b] = '0;
    repeat (10) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    store(dram_wb_pkg::REQ_STORE, 5'h00, 4'h3, {4{32'h1234abcd}},
          16'h0000, 1'b0);
    fetch(4'h3);
    store(dram_wb_pkg::REQ_STORE, 5'h00, 4'h3, {16{8'h5a}},
          16'h00f1, 1'b1);
    fetch(4'h3);
    store(dram_wb_pkg::REQ_STORE, 5'h01, 4'h3, {16{8'hc3}},
          16'h0000, 1'b0);
    fetch(4'h3);
    store(dram_wb_pkg::REQ_STORE_CLOSE, 5'h00, 4'h4, {8{16'h9e07}},
          16'h0000, 1'b0);
    fetch(4'h4);
    // Back to back stores fill the request FIFO until it refuses
    for (int b = 5; b < 11; b++) begin
      store(dram_wb_pkg::REQ_STORE, 5'h00, 4'(b), {16{8'h30 + 8'(b)}},
            16'h0000, 1'b0);
    end
    for (int b = 5; b < 11; b++) fetch(4'(b));
    repeat (20) @(negedge sys_clk_in);
    `CHECK("fifo refused", 1'b1, saw_full)
    `CHECK("buffer held", 1'b1, saw_pending)
    `CHECK("buffer drained", 1'b0, buf_pending_out)
    `CHECK("autoclose pulses", 1, n_autoclose)
    finish_test();
  end
endmodule
